// ===== rtl/dcpm_pkg.sv
// shared constants of the drive common parameter map
package dcpm_pkg;

	// word addresses of the common area
	localparam logic [15:0] ADDR_MODEL     = 16'h0000;
	localparam logic [15:0] ADDR_RATING    = 16'h0001;
	localparam logic [15:0] ADDR_SUPPLY    = 16'h0002;
	localparam logic [15:0] ADDR_FIRMWARE  = 16'h0003;
	localparam logic [15:0] ADDR_LOCK      = 16'h0004;
	localparam logic [15:0] ADDR_SETPOINT  = 16'h0005;
	localparam logic [15:0] ADDR_MOTION    = 16'h0006;
	localparam logic [15:0] ADDR_RAMP_UP   = 16'h0007;
	localparam logic [15:0] ADDR_RAMP_DOWN = 16'h0008;
	localparam logic [15:0] ADDR_CURRENT   = 16'h0009;
	localparam logic [15:0] ADDR_FREQ      = 16'h000A;
	localparam logic [15:0] ADDR_VOLT      = 16'h000B;
	localparam logic [15:0] ADDR_BUS_VOLT  = 16'h000C;
	localparam logic [15:0] ADDR_POWER     = 16'h000D;
	localparam logic [15:0] ADDR_STATE     = 16'h000E;
	localparam logic [15:0] ADDR_FAULT_A   = 16'h000F;
	localparam logic [15:0] ADDR_DIG_IN    = 16'h0010;
	localparam logic [15:0] ADDR_DIG_OUT   = 16'h0011;
	localparam logic [15:0] ADDR_VOLT_POS  = 16'h0012;
	localparam logic [15:0] ADDR_VOLT_NEG  = 16'h0013;
	localparam logic [15:0] ADDR_AN_CURR   = 16'h0014;
	localparam logic [15:0] ADDR_SPEED     = 16'h0015;
	localparam logic [15:0] ADDR_UNIT_RSV  = 16'h001A;
	localparam logic [15:0] ADDR_POLES_RSV = 16'h001B;
	localparam logic [15:0] ADDR_BUILD_RSV = 16'h001C;
	localparam logic [15:0] ADDR_FAULT_B   = 16'h001D;

	// reset values of the writable words
	localparam logic        LOCK_RESET      = 1'h0;
	localparam logic        LOCK_LOCKED     = 1'h0;
	localparam logic [15:0] SETPOINT_RESET  = 16'h0000;
	localparam logic [15:0] RAMP_UP_RESET   = 16'h0000;
	localparam logic [15:0] RAMP_DOWN_RESET = 16'h0000;

	// motion command word fields
	localparam int MC_STOP      = 0;
	localparam int MC_FWD       = 1;
	localparam int MC_REV       = 2;
	localparam int MC_FLT_RESET = 3;
	localparam int MC_ESTOP     = 4;
	localparam int MC_RUN_SRC   = 6;
	localparam int MC_FREQ_SRC  = 8;

	// run command source codes
	localparam logic [1:0] RSRC_TERMINAL = 2'h0;
	localparam logic [1:0] RSRC_KEYPAD   = 2'h1;
	localparam logic [1:0] RSRC_RESERVED = 2'h2;
	localparam logic [1:0] RSRC_COMM     = 2'h3;

	// frequency command source codes (20 and above are reserved)
	localparam logic [4:0] FSRC_STEP_LAST = 5'h08;
	localparam logic [4:0] FSRC_UP        = 5'h09;
	localparam logic [4:0] FSRC_DOWN      = 5'h0A;
	localparam logic [4:0] FSRC_UPDOWN_ZERO_SOURCE    = 5'h0B;
	localparam logic [4:0] FSRC_AN_FIRST  = 5'h0C;
	localparam logic [4:0] FSRC_JOG       = 5'h11;
	localparam logic [4:0] FSRC_PID       = 5'h12;
	localparam logic [4:0] FSRC_COMM      = 5'h13;

	// masks of bits that exist; everything else reads zero
	localparam logic [15:0] STATE_MASK  = 16'h7DFF;
	localparam logic [15:0] DIGOUT_MASK = 16'h0090;

	// speed source setting that enables the negative voltage reading
	localparam logic [3:0] SRC_SET_NEG_VOLT = 4'h2;

	// answer codes, two ascii characters each
	localparam logic [15:0] ERR_NONE      = 16'h0000;
	localparam logic [15:0] ERR_BAD_ADDR  = 16'h4941;
	localparam logic [15:0] ERR_WRITE_MOD = 16'h574D;

endpackage

// ===== rtl/dcpm_register_bank.sv
`timescale 1ns/1ps
// Function
// R1: same layout regardless of drive model
// R2: lock word 0 locked default, 1 unlocked
// R3: bit 3 rising write triggers fault reset
// R4: bits 0-2 stop, forward, reverse, read/write
// R5: bit 4 write issues emergency stop; here only a written 0 to 1 of bit 4 fires the stop event
// R6: bits 6-7 report run command source
// R7: bits 8-12 report frequency command source
// R8: codes 0-11 step speeds and up/down
// R9: codes 12-19 analog, jog, pid, comms
// R10: status bits 0-5 give run conditions
// R11: status bits 6,7,8,10 arrival, braking, stopping
// R12: status bits 11-14 commands and remote selects
// R13: trip bits 0-8 first fault group
// R14: trip bits 9-15 second fault group
// R15: output terminals bit 4 and bit 7
// R16: positive voltage reading ten bits
// R17: negative voltage reading valid at setting 2
// R18: current input reading ten bits
// R19: second trip word bit 0 io reset
// R20: sixteen-bit words, consecutive reads by master
// R21: refuse writes to read-only words
// R22: written values revert on drive reset
// R23: unused bits read zero, ignore writes
// R24: live words sampled at each read
module dcpm_register_bank #(
	parameter logic [15:0] MODEL_CODE    = 16'h00F0, // arbitrary value
	parameter logic [15:0] POWER_RATING  = 16'h0000, // plain default
	parameter logic [15:0] SUPPLY_CLASS  = 16'h0000, // plain default
	parameter logic [15:0] FIRMWARE_REV  = 16'h0217, // arbitrary value
	parameter int          ANALOG_WIDTH  = 10
) (
	input  wire logic                    sys_clk,
	input  wire logic                    rstn,
	// word access from the serial frame engine
	input  wire logic                    reqValid,
	input  wire logic                    reqWrite,
	input  wire logic [15:0]             reqAddr,
	input  wire logic [15:0]             reqWdata,
	output logic                         rspValid,
	output logic [15:0]                  rspRdata,
	output logic [15:0]                  rspError,
	// live drive state
	input  wire logic [1:0]              runSource,
	input  wire logic [4:0]              freqSource,
	input  wire logic [3:0]              speedSourceSetting,
	input  wire logic [15:0]             loadCurrent,
	input  wire logic [15:0]             driveFreq,
	input  wire logic [15:0]             driveVolt,
	input  wire logic [15:0]             busVoltage,
	input  wire logic [15:0]             deliveredPower,
	input  wire logic [15:0]             shaftSpeed,
	input  wire logic [15:0]             driveStateFlags,
	input  wire logic [15:0]             faultFlagsA,
	input  wire logic                    ioBoardResetFault,
	input  wire logic [7:0]              digitalInLevels,
	input  wire logic                    openCollectorOutput,
	input  wire logic                    relayContactOutput,
	input  wire logic [ANALOG_WIDTH-1:0] analogVoltPos,
	input  wire logic [ANALOG_WIDTH-1:0] analogVoltNeg,
	input  wire logic [ANALOG_WIDTH-1:0] analogCurrent,
	// settings and commands towards the drive
	output logic                         settingsUnlocked,
	output logic [15:0]                  speedSetpoint,
	output logic [15:0]                  rampUpTime,
	output logic [15:0]                  rampDownTime,
	output logic                         stopCmd,
	output logic                         forwardCmd,
	output logic                         reverseCmd,
	output logic                         faultResetPulse,
	output logic                         emergencyStopPulse
);

	// writable state
	logic        lock_q;          // 0 locked, 1 unlocked
	logic [15:0] setpoint_q;      // frequency reference, 0.01 Hz
	logic [15:0] rampUp_q;        // acceleration time, 0.1 s
	logic [15:0] rampDown_q;      // deceleration time, 0.1 s
	logic [2:0]  motion_q;        // stop, forward, reverse bits
	logic        fltResetLast_q;  // last written fault reset bit
	logic        estopLast_q;     // last written emergency stop bit
	logic        fltResetPulse_q; // one-cycle fault reset event
	logic        estopPulse_q;    // one-cycle emergency stop event

	// answer path
	logic        rspValid_q;
	logic [15:0] rspRdata_q;
	logic [15:0] rspError_q;

	// decoded view of the current request
	logic        addrKnown;       // address lies in the common area
	logic        addrWritable;    // address accepts a write
	logic        writeOk;         // write will be stored
	logic [15:0] readWord;        // live value of the addressed word
	logic [15:0] motionWord;      // assembled motion command word
	logic [15:0] stateWord;       // drive state with holes cleared
	logic [15:0] negVoltWord;     // gated negative voltage reading

	// decode map; identical for every model, nothing depends on the
	// model code, so a master needs no per-model table
	always_comb begin // R1
		addrKnown = 1'b1;
		addrWritable = 1'b0;
		unique case (reqAddr)
			dcpm_pkg::ADDR_LOCK,
			dcpm_pkg::ADDR_SETPOINT,
			dcpm_pkg::ADDR_MOTION,
			dcpm_pkg::ADDR_RAMP_UP,
			dcpm_pkg::ADDR_RAMP_DOWN: begin
				// settings and the motion word take writes
				addrWritable = 1'b1;
			end
			dcpm_pkg::ADDR_MODEL,
			dcpm_pkg::ADDR_RATING,
			dcpm_pkg::ADDR_SUPPLY,
			dcpm_pkg::ADDR_FIRMWARE,
			dcpm_pkg::ADDR_CURRENT,
			dcpm_pkg::ADDR_FREQ,
			dcpm_pkg::ADDR_VOLT,
			dcpm_pkg::ADDR_BUS_VOLT,
			dcpm_pkg::ADDR_POWER,
			dcpm_pkg::ADDR_STATE,
			dcpm_pkg::ADDR_FAULT_A,
			dcpm_pkg::ADDR_DIG_IN,
			dcpm_pkg::ADDR_DIG_OUT,
			dcpm_pkg::ADDR_VOLT_POS,
			dcpm_pkg::ADDR_VOLT_NEG,
			dcpm_pkg::ADDR_AN_CURR,
			dcpm_pkg::ADDR_SPEED,
			dcpm_pkg::ADDR_UNIT_RSV,
			dcpm_pkg::ADDR_POLES_RSV,
			dcpm_pkg::ADDR_BUILD_RSV,
			dcpm_pkg::ADDR_FAULT_B: begin
				// readable only
				addrWritable = 1'b0;
			end
			default: begin
				// outside the common area
				addrKnown = 1'b0;
			end
		endcase
	end

	// a write is stored only on a writable word
	assign writeOk = reqValid && reqWrite && addrWritable; // R21

	// motion command word as it reads back; the event bits 3 and 4
	// are write-only and bits 5 and 13 to 15 do not exist
	always_comb begin
		motionWord = 16'h0000; // R23
		motionWord[dcpm_pkg::MC_STOP] = motion_q[0]; // R4
		motionWord[dcpm_pkg::MC_FWD] = motion_q[1]; // R4
		motionWord[dcpm_pkg::MC_REV] = motion_q[2]; // R4
		motionWord[dcpm_pkg::MC_RUN_SRC +: 2] = runSource; // R6
		// all 32 codes pass through, reserved ones included, so the
		// master sees exactly what the drive has selected
		motionWord[dcpm_pkg::MC_FREQ_SRC +: 5] = freqSource; // R7 R8 R9
	end

	// drive state: bits 9 and 15 are holes
	assign stateWord = driveStateFlags & dcpm_pkg::STATE_MASK; // R10 R11 R12

	// negative input only means something in one speed source setting
	always_comb begin
		negVoltWord = 16'h0000;
		if (speedSourceSetting == dcpm_pkg::SRC_SET_NEG_VOLT) begin // R17
			negVoltWord[ANALOG_WIDTH-1:0] = analogVoltNeg;
		end
	end

	// read multiplexer; live inputs are picked at the request edge so
	// the answer reflects the drive at that moment
	always_comb begin // R24
		readWord = 16'h0000; // R23
		unique case (reqAddr)
			// identity words, fixed for a build
			dcpm_pkg::ADDR_MODEL: begin
				readWord = MODEL_CODE;
			end
			dcpm_pkg::ADDR_RATING: begin
				readWord = POWER_RATING;
			end
			dcpm_pkg::ADDR_SUPPLY: begin
				readWord = SUPPLY_CLASS;
			end
			dcpm_pkg::ADDR_FIRMWARE: begin
				readWord = FIRMWARE_REV;
			end
			// writable settings read back as stored
			dcpm_pkg::ADDR_LOCK: begin
				readWord[0] = lock_q; // R2
			end
			dcpm_pkg::ADDR_SETPOINT: begin
				readWord = setpoint_q;
			end
			dcpm_pkg::ADDR_MOTION: begin
				readWord = motionWord;
			end
			dcpm_pkg::ADDR_RAMP_UP: begin
				readWord = rampUp_q;
			end
			dcpm_pkg::ADDR_RAMP_DOWN: begin
				readWord = rampDown_q;
			end
			// live measurements pass straight through
			dcpm_pkg::ADDR_CURRENT: begin
				readWord = loadCurrent;
			end
			dcpm_pkg::ADDR_FREQ: begin
				readWord = driveFreq;
			end
			dcpm_pkg::ADDR_VOLT: begin
				readWord = driveVolt;
			end
			dcpm_pkg::ADDR_BUS_VOLT: begin
				readWord = busVoltage;
			end
			dcpm_pkg::ADDR_POWER: begin
				readWord = deliveredPower;
			end
			// live flag words
			dcpm_pkg::ADDR_STATE: begin
				readWord = stateWord;
			end
			dcpm_pkg::ADDR_FAULT_A: begin
				readWord = faultFlagsA; // R13 R14
			end
			dcpm_pkg::ADDR_DIG_IN: begin
				readWord[7:0] = digitalInLevels;
			end
			dcpm_pkg::ADDR_DIG_OUT: begin
				readWord[4] = openCollectorOutput; // R15
				readWord[7] = relayContactOutput; // R15
			end
			// analog readings fill the low bits only
			dcpm_pkg::ADDR_VOLT_POS: begin
				readWord[ANALOG_WIDTH-1:0] = analogVoltPos; // R16
			end
			dcpm_pkg::ADDR_VOLT_NEG: begin
				readWord = negVoltWord;
			end
			dcpm_pkg::ADDR_AN_CURR: begin
				readWord[ANALOG_WIDTH-1:0] = analogCurrent; // R18
			end
			dcpm_pkg::ADDR_SPEED: begin
				readWord = shaftSpeed;
			end
			dcpm_pkg::ADDR_FAULT_B: begin
				readWord[0] = ioBoardResetFault; // R19
			end
			default: begin
				// reserved words and unknown addresses read zero
				readWord = 16'h0000;
			end
		endcase
	end

	// parameter lock word; only bit 0 is kept
	// the lock only drives an output; it gates no other write
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			lock_q <= dcpm_pkg::LOCK_RESET; // R22
		end else if (writeOk && reqAddr == dcpm_pkg::ADDR_LOCK) begin
			lock_q <= reqWdata[0]; // R2
		end
	end

	// setpoint and ramp words; held only until the next drive reset
	// no range check here: every 16-bit value is stored as written
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			setpoint_q <= dcpm_pkg::SETPOINT_RESET; // R22
			rampUp_q <= dcpm_pkg::RAMP_UP_RESET; // R22
			rampDown_q <= dcpm_pkg::RAMP_DOWN_RESET; // R22
		end else if (writeOk) begin
			// takes effect on the next edge
			if (reqAddr == dcpm_pkg::ADDR_SETPOINT) begin
				setpoint_q <= reqWdata;
			end
			if (reqAddr == dcpm_pkg::ADDR_RAMP_UP) begin
				rampUp_q <= reqWdata;
			end
			if (reqAddr == dcpm_pkg::ADDR_RAMP_DOWN) begin
				rampDown_q <= reqWdata;
			end
		end
	end

	// run bits of the motion word; other written bits are dropped
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			motion_q <= 3'h0;
		end else if (writeOk && reqAddr == dcpm_pkg::ADDR_MOTION) begin
			motion_q <= reqWdata[dcpm_pkg::MC_REV:dcpm_pkg::MC_STOP]; // R4
		end
	end

	// fault reset event: the last written level is remembered so that
	// only a written rising edge fires; writing 1 twice fires once,
	// which keeps a repeated frame from resetting faults a second time
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			// both start low, so the first written 1 is an edge
			fltResetLast_q <= 1'b0;
			fltResetPulse_q <= 1'b0;
		end else if (writeOk && reqAddr == dcpm_pkg::ADDR_MOTION) begin
			// remember the level and fire on a written 0 to 1
			fltResetLast_q <= reqWdata[dcpm_pkg::MC_FLT_RESET];
			fltResetPulse_q <= reqWdata[dcpm_pkg::MC_FLT_RESET] &&
				!fltResetLast_q; // R3
		end else begin
			// the event lasts a single cycle
			fltResetPulse_q <= 1'b0;
		end
	end

	// emergency stop event, same edge rule as the fault reset; the
	// drive side must latch the stop, this is only a one-cycle event
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			// nothing written yet
			estopLast_q <= 1'b0;
			estopPulse_q <= 1'b0;
		end else if (writeOk && reqAddr == dcpm_pkg::ADDR_MOTION) begin
			// remember the level and fire on a written 0 to 1
			estopLast_q <= reqWdata[dcpm_pkg::MC_ESTOP];
			estopPulse_q <= reqWdata[dcpm_pkg::MC_ESTOP] &&
				!estopLast_q; // R5
		end else begin
			// the event lasts a single cycle
			estopPulse_q <= 1'b0;
		end
	end

	// answer: one cycle after every request, data or an error code
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			rspValid_q <= 1'b0;
			rspRdata_q <= 16'h0000;
			rspError_q <= dcpm_pkg::ERR_NONE;
		end else begin
			rspValid_q <= reqValid; // R20
			if (reqValid) begin
				// the master walks consecutive words one request each
				rspRdata_q <= readWord; // R20
				if (!addrKnown) begin
					// no such word: nothing stored, data reads zero
					rspError_q <= dcpm_pkg::ERR_BAD_ADDR;
				end else if (reqWrite && !addrWritable) begin
					// read-only or reserved word: the write is dropped
					rspError_q <= dcpm_pkg::ERR_WRITE_MOD; // R21
				end else begin
					// accepted read or stored write
					rspError_q <= dcpm_pkg::ERR_NONE;
				end
			end
		end
	end

	// outputs come straight from flip-flops
	assign rspValid = rspValid_q;
	assign rspRdata = rspRdata_q;
	assign rspError = rspError_q;
	assign settingsUnlocked = (lock_q != dcpm_pkg::LOCK_LOCKED); // R2
	assign speedSetpoint = setpoint_q;
	assign rampUpTime = rampUp_q;
	assign rampDownTime = rampDown_q;
	assign stopCmd = motion_q[0];
	assign forwardCmd = motion_q[1];
	assign reverseCmd = motion_q[2];
	assign faultResetPulse = fltResetPulse_q;
	assign emergencyStopPulse = estopPulse_q;

endmodule

// ===== test/dcpm_checker.sv
`timescale 1ns/1ps
// watches the word port and the settings outputs of the bank
module dcpm_checker (
	input wire logic        sys_clk,
	input wire logic        rstn,
	input wire logic        reqValid,
	input wire logic        reqWrite,
	input wire logic [15:0] reqAddr,
	input wire logic [15:0] reqWdata,
	input wire logic        rspValid,
	input wire logic [15:0] rspRdata,
	input wire logic [15:0] rspError,
	input wire logic [15:0] driveStateFlags,
	input wire logic        settingsUnlocked,
	input wire logic [15:0] speedSetpoint,
	input wire logic        stopCmd,
	input wire logic        forwardCmd,
	input wire logic        reverseCmd,
	input wire logic        faultResetPulse,
	input wire logic        emergencyStopPulse
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	// decoded requests
	wire wr = reqValid && reqWrite;
	wire wrLock = wr && reqAddr == 16'h0004;
	wire wrSet = wr && reqAddr == 16'h0005;
	wire wrCmd = wr && reqAddr == 16'h0006;
	wire rdState = reqValid && !reqWrite && reqAddr == 16'h000E;
	// read-only words: identity and the live readings 9 to 0x15, not the second trip word
	wire wrRo = wr && (reqAddr < 16'h0004
		|| (reqAddr >= 16'h0009 && reqAddr <= 16'h0015));

	property p_rsp_next; reqValid |=> rspValid; endproperty
	a_rsp_next: assert property (p_rsp_next) else $error("no answer");
	property p_rsp_only; !reqValid |=> !rspValid; endproperty
	a_rsp_only: assert property (p_rsp_only) else $error("stray ack");
	property p_lock;
		wrLock |=> settingsUnlocked == $past(reqWdata[0]);
	endproperty
	a_lock: assert property (p_lock) else $error("lock output wrong");
	property p_cmd;
		wrCmd |=> {reverseCmd, forwardCmd, stopCmd}
			== $past(reqWdata[2:0]);
	endproperty
	a_cmd: assert property (p_cmd) else $error("run levels wrong");
	property p_fault;
		faultResetPulse |-> $past(wrCmd && reqWdata[3]);
	endproperty
	a_fault: assert property (p_fault) else $error("stray fault reset");
	property p_fault_one; faultResetPulse |=> !faultResetPulse; endproperty
	a_fault_one: assert property (p_fault_one) else $error("long pulse");
	property p_estop;
		emergencyStopPulse |-> $past(wrCmd && reqWdata[4]);
	endproperty
	a_estop: assert property (p_estop) else $error("stray stop pulse");
	property p_ro; wrRo |=> rspError == 16'h574D; endproperty
	a_ro: assert property (p_ro) else $error("write not refused");
	property p_state;
		rdState |=> rspRdata == ($past(driveStateFlags) & 16'h7DFF);
	endproperty
	a_state: assert property (p_state) else $error("status word wrong");
	property p_set; wrSet |=> speedSetpoint == $past(reqWdata); endproperty
	a_set: assert property (p_set) else $error("setpoint not taken");

	// main scenarios reached
	c_fault: cover property (faultResetPulse);
	c_estop: cover property (emergencyStopPulse);
	c_refuse: cover property (rspValid && rspError == 16'h574D);
endmodule

// ===== test/dcpm_master_model.sv
`timescale 1ns/1ps
// serial master side, as the frame engine hands its words on
module dcpm_master_model (
	input  wire logic        sys_clk,
	output logic             reqValid,
	output logic             reqWrite,
	output logic [15:0]      reqAddr,
	output logic [15:0]      reqWdata,
	input  wire logic        rspValid,
	input  wire logic [15:0] rspRdata,
	input  wire logic [15:0] rspError
);
	// idle until the first request
	initial begin
		reqValid = 1'b0;
		reqWrite = 1'b0;
		reqAddr = 16'h0000;
		reqWdata = 16'h0000;
	end
	// one 16-bit word per request; released lines show inverted
	// values so a design that samples late cannot pass by luck
	task automatic xfer(input logic w, input logic [15:0] a, d,
		output logic [15:0] q, e, output logic ok);
		ok = 1'b0;
		@(posedge sys_clk);
		reqValid <= 1'b1;
		reqWrite <= w;
		reqAddr <= a;
		reqWdata <= d;
		// bounded wait for the answer
		for (int i = 0; i < 4 && !ok; i++) begin
			@(posedge sys_clk);
			reqValid <= 1'b0;
			reqWrite <= ~w;
			reqAddr <= ~a;
			reqWdata <= ~d;
			#1;
			if (rspValid === 1'b1) begin
				ok = 1'b1;
				q = rspRdata;
				e = rspError;
			end
		end
	endtask
endmodule

// ===== test/drive_common_parameter_map_test.sv
`timescale 1ns/1ps
bind dcpm_register_bank dcpm_checker chk (.sys_clk, .rstn, .reqValid,
	.reqWrite, .reqAddr, .reqWdata, .rspValid, .rspRdata, .rspError,
	.driveStateFlags, .settingsUnlocked, .speedSetpoint, .stopCmd,
	.forwardCmd, .reverseCmd, .faultResetPulse, .emergencyStopPulse);

module drive_common_parameter_map_test;
	localparam logic [15:0] MODEL = 16'h00F0; // arbitrary value
	localparam logic [15:0] FWREV = 16'h0217; // arbitrary value
	logic sys_clk, rstn, reqValid, reqWrite, rspValid, settingsUnlocked;
	logic stopCmd, forwardCmd, reverseCmd, faultResetPulse;
	logic emergencyStopPulse, ioBoardResetFault;
	logic openCollectorOutput, relayContactOutput;
	logic [15:0] reqAddr, reqWdata, rspRdata, rspError, speedSetpoint;
	logic [15:0] rampUpTime, rampDownTime, loadCurrent, driveFreq;
	logic [15:0] driveVolt, busVoltage, deliveredPower, shaftSpeed;
	logic [15:0] driveStateFlags, faultFlagsA;
	logic [1:0]  runSource;
	logic [4:0]  freqSource;
	logic [3:0]  speedSourceSetting;
	logic [7:0]  digitalInLevels;
	logic [9:0]  analogVoltPos, analogVoltNeg, analogCurrent;
	int          errorCnt, nChecks, frCnt, esCnt;

	dcpm_register_bank #(.MODEL_CODE(MODEL), .FIRMWARE_REV(FWREV)) uut (
		.sys_clk, .rstn, .reqValid, .reqWrite, .reqAddr, .reqWdata,
		.rspValid, .rspRdata, .rspError, .runSource, .freqSource,
		.speedSourceSetting, .loadCurrent, .driveFreq, .driveVolt,
		.busVoltage, .deliveredPower, .shaftSpeed, .driveStateFlags,
		.faultFlagsA, .ioBoardResetFault, .digitalInLevels,
		.openCollectorOutput, .relayContactOutput, .analogVoltPos,
		.analogVoltNeg, .analogCurrent, .settingsUnlocked, .speedSetpoint,
		.rampUpTime, .rampDownTime, .stopCmd, .forwardCmd, .reverseCmd,
		.faultResetPulse, .emergencyStopPulse);
	dcpm_master_model m (.sys_clk, .reqValid, .reqWrite, .reqAddr,
		.reqWdata, .rspValid, .rspRdata, .rspError);

	initial begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end
	// pulses last one cycle, so count them at every edge
	always @(posedge sys_clk) begin
		frCnt += int'(faultResetPulse === 1'b1);
		esCnt += int'(emergencyStopPulse === 1'b1);
	end

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", nChecks, errorCnt);
		if (errorCnt == 0 && nChecks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	task automatic chk(input string n, input logic [15:0] e, g);
		nChecks++;
		if (g !== e) begin
			errorCnt++;
			$display("unexpected %s: expected %h seen %h", n, e, g);
		end
	endtask
	// one word access; read data is judged only on reads
	task automatic acc(input logic w, input logic [15:0] a, d, e, er);
		logic [15:0] q, r;
		logic ok;
		m.xfer(w, a, d, q, r, ok);
		if (!ok) begin
			errorCnt++;
			wrap_up();
		end
		if (!w) chk("rdata", e, q);
		chk("error", er, r);
	endtask
	task automatic rd(input logic [15:0] a, e);
		acc(1'b0, a, 16'h0000, e, 16'h0000);
	endtask
	task automatic wr(input logic [15:0] a, d);
		acc(1'b1, a, d, 16'h0000, 16'h0000);
	endtask

	// identity words and lock default after reset
	task automatic t_ident();
		rd(16'h0000, MODEL);
		rd(16'h0003, FWREV);
		rd(16'h0004, 16'h0000);
		chk("unlocked", 16'h0000, 16'(settingsUnlocked));
	endtask
	// writable words, then a reset in mid-run drops them
	task automatic t_settings();
		wr(16'h0004, 16'h0001);
		rd(16'h0004, 16'h0001);
		chk("unlocked", 16'h0001, 16'(settingsUnlocked));
		wr(16'h0005, 16'hA5C3);
		wr(16'h0007, 16'h1234);
		wr(16'h0008, 16'hFEDC);
		rd(16'h0005, 16'hA5C3);
		chk("ramp up", 16'h1234, rampUpTime);
		chk("ramp down", 16'hFEDC, rampDownTime);
		rd(16'h0008, 16'hFEDC);
		@(posedge sys_clk) rstn <= 1'b0;
		@(posedge sys_clk) rstn <= 1'b1;
		chk("setpoint", 16'h0000, speedSetpoint);
		rd(16'h0004, 16'h0000);
	endtask
	// run levels, edge events and ignored bits of the command word
	task automatic t_motion();
		int f0, e0;
		@(posedge sys_clk) runSource <= 2'h3;
		freqSource <= 5'h13;
		wr(16'h0006, 16'h0002);
		rd(16'h0006, 16'h13C2);
		wr(16'h0006, 16'h0004);
		chk("reverse", 16'h0001, 16'(reverseCmd));
		wr(16'h0006, 16'h0001);
		chk("run", 16'h0001, 16'({reverseCmd, forwardCmd, stopCmd}));
		f0 = frCnt;
		e0 = esCnt;
		wr(16'h0006, 16'h8038);
		rd(16'h0006, 16'h13C0);
		wr(16'h0006, 16'h0018);
		chk("fault pulses", 16'h0001, 16'(frCnt - f0));
		chk("stop pulses", 16'h0001, 16'(esCnt - e0));
	endtask
	// every source code passes through its field
	task automatic t_sources();
		for (int i = 0; i < 32; i++) begin
			@(posedge sys_clk) freqSource <= 5'(i);
			runSource <= 2'(i);
			rd(16'h0006, {3'h0, 5'(i), 2'(i), 6'h00});
		end
	endtask
	// live words sampled at each read
	task automatic t_live();
		@(posedge sys_clk) driveStateFlags <= 16'hFFFF;
		faultFlagsA <= 16'hA55A;
		{ioBoardResetFault, openCollectorOutput, relayContactOutput} <= 3'h7;
		{analogVoltPos, analogVoltNeg, analogCurrent} <= {30{1'b1}};
		{loadCurrent, driveFreq, driveVolt} <= 48'h0109_010A_010B;
		{busVoltage, deliveredPower, shaftSpeed} <= 48'h010C_010D_0115;
		digitalInLevels <= 8'hC3;
		speedSourceSetting <= 4'h1;
		for (int a = 9; a < 14; a++) rd(16'(a), 16'h0100 | 16'(a));
		rd(16'h0015, 16'h0115);
		rd(16'h000E, 16'h7DFF);
		rd(16'h000F, 16'hA55A);
		rd(16'h0010, 16'h00C3);
		rd(16'h0011, 16'h0090);
		rd(16'h0012, 16'h03FF);
		rd(16'h0014, 16'h03FF);
		rd(16'h0013, 16'h0000);
		rd(16'h001D, 16'h0001);
		@(posedge sys_clk) speedSourceSetting <= 4'h2;
		driveStateFlags <= 16'h0241;
		rd(16'h0013, 16'h03FF);
		rd(16'h000E, 16'h0041);
	endtask
	// refused writes and reserved or missing words
	task automatic t_refuse();
		acc(1'b1, 16'h0009, 16'h5555, 16'h0000, 16'h574D);
		rd(16'h0009, 16'h0109);
		acc(1'b1, 16'h0000, 16'h5555, 16'h0000, 16'h574D);
		rd(16'h0000, MODEL);
		acc(1'b1, 16'h001A, 16'h5555, 16'h0000, 16'h574D);
		rd(16'h001B, 16'h0000);
		acc(1'b0, 16'h0016, 16'h0000, 16'h0000, 16'h4941);
	endtask

	// watchdog against a hang
	initial begin
		repeat (20000) @(posedge sys_clk);
		errorCnt++;
		wrap_up();
	end
	initial begin
		rstn = 1'b0;
		{runSource, freqSource, speedSourceSetting, digitalInLevels} = '0;
		{loadCurrent, driveFreq, driveVolt, busVoltage} = '0;
		{deliveredPower, shaftSpeed, driveStateFlags, faultFlagsA} = '0;
		{ioBoardResetFault, openCollectorOutput, relayContactOutput} = '0;
		{analogVoltPos, analogVoltNeg, analogCurrent} = '0;
		repeat (5) @(posedge sys_clk);
		rstn <= 1'b1;
		t_ident();
		t_settings();
		t_motion();
		t_sources();
		t_live();
		t_refuse();
		wrap_up();
	end
endmodule
